// ==== rsp_pkg.sv ====
// Purpose: shared constants for the radio serial slave port
// Assumes: one 100 MHz clock, byte wide registers with six bit addresses
// Notes:   clock output selections count down from the crystal rate
package rsp_pkg;
   localparam int        DATA_W       = 8;
   localparam int        ADDR_W       = 6;
   localparam int        CMD_DIR_BIT  = 7;
   localparam int        CMD_INC_BIT  = 6;
   localparam logic [2:0] BIT_LAST    = 3'h7;
   localparam logic [2:0] CLKSEL_12M  = 3'h0;
   localparam logic [2:0] CLKSEL_6M   = 3'h1;
   localparam logic [2:0] CLKSEL_3M   = 3'h2;
   localparam logic [2:0] CLKSEL_1M5  = 3'h3;
   localparam logic [2:0] CLKSEL_0M75 = 3'h4;
   localparam logic [3:0] DIV_RST     = 4'h0;

   typedef enum logic [2:0] {
      RSP_IDLE = 3'b001,
      RSP_CMD  = 3'b010,
      RSP_DATA = 3'b100
   } rsp_state_t;
endpackage : rsp_pkg

// ==== rsp_clkout.sv ====
// Purpose: selectable digital clock output derived from crystal ticks
// Assumes: xtal_tick pulses once per half period of the fastest output
// Notes:   output parks low the cycle after disable, cutting short any high phase in progress
module rsp_clkout (
   input  wire logic       mclk,
   input  wire logic       rst,
   input  wire logic       xtal_tick,
   input  wire logic       clkout_off,
   input  wire logic [2:0] clkout_sel,
   output logic            clk_o
);
   logic [3:0] div;
   logic [3:0] next_div;
   logic       next_clk_o;
   logic [3:0] limit;

   // toggle after 2^sel ticks, selection above the slowest clamps to it
   always_comb begin
      case (clkout_sel)
         rsp_pkg::CLKSEL_12M:  limit = 4'h0;
         rsp_pkg::CLKSEL_6M:   limit = 4'h1;
         rsp_pkg::CLKSEL_3M:   limit = 4'h3;
         rsp_pkg::CLKSEL_1M5:  limit = 4'h7;
         default:              limit = 4'hf;
      endcase
      next_div   = div;
      next_clk_o = clk_o;
      if (clkout_off) begin
         next_div   = rsp_pkg::DIV_RST;
         next_clk_o = 1'b0;
      end else if (xtal_tick) begin
         if (div >= limit) begin
            next_div   = rsp_pkg::DIV_RST;
            next_clk_o = ~clk_o;
         end else begin
            next_div = div + 4'h1;
         end
      end
   end

   // register stage
   always_ff @(posedge mclk) begin
      if (rst) begin
         div   <= rsp_pkg::DIV_RST;
         clk_o <= 1'b0;
      end else begin
         div   <= next_div;
         clk_o <= next_clk_o;
      end
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   chk_clkout_parked: assert property (clkout_off |=> !clk_o)
      else $error("clock output not parked while disabled");
   chk_clkout_fastest: assert property
      (!clkout_off && clkout_sel == rsp_pkg::CLKSEL_12M && xtal_tick |=> clk_o != $past(clk_o))
      else $error("fastest clock output missed a toggle");
   cov_clkout_slow: cover property (clkout_sel == rsp_pkg::CLKSEL_0M75 && $rose(clk_o));
endmodule : rsp_clkout

// ==== rsp_port.sv ====
// Purpose: serial slave port for register and fifo access, interrupt pin, clock out
// Assumes: sck, ss_n and mosi are pins sampled by two flops; sck half period > 6 mclk
// Notes:   runs on mclk only, never on the crystal oscillator
module rsp_port (
   input  wire logic                       mclk,
   input  wire logic                       rst,
   input  wire logic                       ss_n,
   input  wire logic                       sck,
   input  wire logic                       mosi_i,
   output logic                            mosi_o,
   output logic                            mosi_oe,
   output logic                            miso_o,
   output logic                            miso_oe,
   input  wire logic                       spi_3pin,
   input  wire logic                       irq_on_mosi,
   input  wire logic                       irq_pol_high,
   input  wire logic                       irq_open_drain,
   input  wire logic [7:0]                 tx_status,
   input  wire logic [7:0]                 rx_status,
   input  wire logic [7:0]                 sys_status,
   input  wire logic [7:0]                 tx_irq_en,
   input  wire logic [7:0]                 rx_irq_en,
   input  wire logic [7:0]                 sys_irq_en,
   output logic                            irq_o,
   output logic                            irq_oe,
   output logic [rsp_pkg::ADDR_W-1:0]      reg_addr,
   output logic [rsp_pkg::DATA_W-1:0]      reg_wdata,
   output logic                            reg_wr,
   output logic                            reg_rd,
   input  wire logic [rsp_pkg::DATA_W-1:0] reg_rdata,
   input  wire logic                       xtal_tick,
   input  wire logic                       clkout_off,
   input  wire logic [2:0]                 clkout_sel,
   output logic                            clkout_o
);
   // pin synchronisers, only the second stage and later are read
   logic ss_s1, ss_s2, sck_s1, sck_s2, sck_q, mosi_s1, mosi_s2;

   rsp_pkg::rsp_state_t              st, next_st;
   logic [2:0]                       cnt, next_cnt;
   logic [7:0]                       shin, next_shin;
   logic [7:0]                       shout, next_shout;
   logic                             dir, next_dir;
   logic                             inc, next_inc;
   logic                             load, next_load;
   logic [rsp_pkg::ADDR_W-1:0]       next_addr;
   logic [7:0]                       next_wdata;
   logic                             next_wr, next_rd;
   logic                             next_mosi_o, next_mosi_oe, next_miso_o, next_miso_oe;
   logic                             next_irq_o, next_irq_oe;
   logic                             rise, fall, done, irq_raw, irq_lvl;
   logic [7:0]                       byte_in;

   // link samples, a rising or falling sck seen once per edge
   always_ff @(posedge mclk) begin
      if (rst) begin
         ss_s1   <= 1'b1;
         ss_s2   <= 1'b1;
         sck_s1  <= 1'b0;
         sck_s2  <= 1'b0;
         sck_q   <= 1'b0;
         mosi_s1 <= 1'b0;
         mosi_s2 <= 1'b0;
      end else begin
         ss_s1   <= ss_n;
         ss_s2   <= ss_s1;
         sck_s1  <= sck;
         sck_s2  <= sck_s1;
         sck_q   <= sck_s2;
         mosi_s1 <= mosi_i;
         mosi_s2 <= mosi_s1;
      end
   end

   assign rise    = sck_s2 & ~sck_q & ~ss_s2;
   assign fall    = ~sck_s2 & sck_q & ~ss_s2;
   assign done    = rise && (cnt == rsp_pkg::BIT_LAST);
   assign byte_in = {shin[6:0], mosi_s2};

   // byte framing, command decode and register strobes
   always_comb begin
      next_st    = st;
      next_cnt   = cnt;
      next_shin  = shin;
      next_shout = shout;
      next_dir   = dir;
      next_inc   = inc;
      next_addr  = reg_addr;
      next_wdata = reg_wdata;
      next_wr    = 1'b0;
      next_rd    = 1'b0;
      next_load  = reg_rd;                     // read data valid one cycle after strobe
      if (reg_wr && inc)
         next_addr = reg_addr + 6'h01;
      if (load)
         next_shout = reg_rdata;
      case (st)
         rsp_pkg::RSP_IDLE: begin
            next_cnt = 3'h0;
            if (!ss_s2)
               next_st = rsp_pkg::RSP_CMD;
         end
         rsp_pkg::RSP_CMD, rsp_pkg::RSP_DATA: begin
            if (rise) begin
               next_shin = byte_in;
               next_cnt  = cnt + 3'h1;
            end
            // shift on falls inside a byte only, so bit 7 stands across the byte gap
            if (fall && cnt != 3'h0 && !load)
               next_shout = {shout[6:0], 1'b0};
            if (done && st == rsp_pkg::RSP_CMD) begin
               next_dir  = byte_in[rsp_pkg::CMD_DIR_BIT];
               next_inc  = byte_in[rsp_pkg::CMD_INC_BIT];
               next_addr = byte_in[rsp_pkg::ADDR_W-1:0];
               next_rd   = ~byte_in[rsp_pkg::CMD_DIR_BIT];
               next_st   = rsp_pkg::RSP_DATA;
            end else if (done) begin
               if (dir) begin
                  next_wdata = byte_in;
                  next_wr    = 1'b1;
               end else begin
                  // prefetch of the next byte: a fifo pops once more at burst end
                  next_addr = reg_addr + {5'h00, inc};
                  next_rd   = 1'b1;
               end
            end
            if (ss_s2)
               next_st = rsp_pkg::RSP_IDLE;
         end
         default: next_st = rsp_pkg::RSP_IDLE;
      endcase
   end

   // pin drivers: read data, and the interrupt level on its chosen pin
   always_comb begin
      irq_raw = |(tx_status & tx_irq_en) | |(rx_status & rx_irq_en)
              | |(sys_status & sys_irq_en);
      irq_lvl = irq_pol_high ? irq_raw : ~irq_raw;
      next_miso_o  = shout[7];
      next_miso_oe = !ss_s2 && !spi_3pin && st == rsp_pkg::RSP_DATA && !dir;
      next_mosi_o  = 1'b0;
      next_mosi_oe = 1'b0;
      next_irq_o   = irq_open_drain ? 1'b0 : irq_lvl;
      next_irq_oe  = irq_open_drain ? ~irq_lvl : 1'b1;
      if (spi_3pin && !ss_s2 && st == rsp_pkg::RSP_DATA && !dir) begin
         next_mosi_o  = shout[7];
         next_mosi_oe = 1'b1;
      end else if (irq_on_mosi && ss_s2) begin
         next_mosi_o  = next_irq_o;
         next_mosi_oe = next_irq_oe;
      end
      if (irq_on_mosi) begin
         next_irq_o  = 1'b0;
         next_irq_oe = 1'b0;
      end
   end

   // register stage, no crystal dependency anywhere on this path
   always_ff @(posedge mclk) begin
      if (rst) begin
         st        <= rsp_pkg::RSP_IDLE;
         cnt       <= 3'h0;
         shin      <= 8'h00;
         shout     <= 8'h00;
         dir       <= 1'b0;
         inc       <= 1'b0;
         load      <= 1'b0;
         reg_addr  <= 6'h00;
         reg_wdata <= 8'h00;
         reg_wr    <= 1'b0;
         reg_rd    <= 1'b0;
         mosi_o    <= 1'b0;
         mosi_oe   <= 1'b0;
         miso_o    <= 1'b0;
         miso_oe   <= 1'b0;
         irq_o     <= 1'b0;
         irq_oe    <= 1'b0;
      end else begin
         st        <= next_st;
         cnt       <= next_cnt;
         shin      <= next_shin;
         shout     <= next_shout;
         dir       <= next_dir;
         inc       <= next_inc;
         load      <= next_load;
         reg_addr  <= next_addr;
         reg_wdata <= next_wdata;
         reg_wr    <= next_wr;
         reg_rd    <= next_rd;
         mosi_o    <= next_mosi_o;
         mosi_oe   <= next_mosi_oe;
         miso_o    <= next_miso_o;
         miso_oe   <= next_miso_oe;
         irq_o     <= next_irq_o;
         irq_oe    <= next_irq_oe;
      end
   end

   rsp_clkout u_clkout (
      .mclk       (mclk),
      .rst        (rst),
      .xtal_tick  (xtal_tick),
      .clkout_off (clkout_off),
      .clkout_sel (clkout_sel),
      .clk_o      (clkout_o)
   );

   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   chk_read_dir: assert property
      (done && st == rsp_pkg::RSP_CMD && !byte_in[7] |=> reg_rd && !reg_wr ##1 load)
      else $error("read command did not fetch");
   chk_write_strobe: assert property
      (done && st == rsp_pkg::RSP_DATA && dir |=> reg_wr && reg_wdata == $past(byte_in))
      else $error("write byte not strobed");
   chk_addr_step: assert property
      (reg_wr && !(done && st == rsp_pkg::RSP_CMD) |=> reg_addr == $past(reg_addr) + 6'($past(inc)))
      else $error("address step wrong after write");
   chk_cmd_addr: assert property
      (done && st == rsp_pkg::RSP_CMD |=> reg_addr == $past(byte_in[5:0]))
      else $error("command address not captured");
   chk_select_idle: assert property
      (ss_s2 |=> st == rsp_pkg::RSP_IDLE ##1 !reg_wr && !reg_rd)
      else $error("activity while select high");
   chk_shift_msb: assert property
      (fall && cnt != 3'h0 && !load && st != rsp_pkg::RSP_IDLE |=> shout == {$past(shout[6:0]), 1'b0})
      else $error("read shift out of order");
   chk_mosi_quiet: assert property
      ((!ss_s2 && !spi_3pin)[*2] |-> !mosi_oe)
      else $error("mosi driven while selected in four pin mode");
   chk_irq_mask: assert property
      (tx_irq_en == 8'h00 && rx_irq_en == 8'h00 && sys_irq_en == 8'h00 && !irq_open_drain
       && !irq_on_mosi |=> irq_oe && irq_o == !$past(irq_pol_high))
      else $error("masked sources reached the pin");
   chk_irq_od: assert property (irq_open_drain |=> !irq_o)
      else $error("open drain pin drove high");

   cov_write_burst: cover property (reg_wr ##[1:300] reg_wr);
   cov_read_burst:  cover property (reg_rd ##[1:300] reg_rd);
   cov_irq_mosi:    cover property (irq_on_mosi && ss_s2 && mosi_oe);
   cov_three_pin:   cover property (spi_3pin && mosi_oe && !ss_s2);
endmodule : rsp_port

// ==== rsp_host_model.sv ====
// Purpose: host master model driving the serial port pins
// Assumes: sck half period of 8 mclk, bytes msb first
// Notes:   host data driver is off unless a byte is being sent
module rsp_host_model (
   input  wire logic mclk,
   input  wire logic spi_3pin,
   input  wire logic miso_pin,
   input  wire logic mosi_pin,
   output logic      ss_n,
   output logic      sck,
   output logic      mosi_d,
   output logic      mosi_en
);
   timeunit 1ns;
   timeprecision 1ps;
   // select idle high, clock parked low outside frames
   initial begin
      ss_n = 1'b1;
      sck = 1'b0;
      mosi_d = 1'b0;
      mosi_en = 1'b0; // released while idle
   end
   // pins change only at falling mclk
   task automatic idle(input int n);
      repeat (n) @(negedge mclk);
   endtask : idle
   // select edges framed by quiet clock
   task automatic sel(input logic v);
      idle(8);
      ss_n = v;
      idle(8);
   endtask : sel
   // one byte; sample on rising sck, change on falling
   task automatic xfer(input logic [7:0] tx, input logic drv, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--) begin
         mosi_en = drv; // off the shared pin unless sending
         mosi_d = tx[i];
         idle(8);
         sck = 1'b1;
         rx[i] = spi_3pin ? mosi_pin : miso_pin;
         idle(8);
         sck = 1'b0;
      end
      mosi_en = 1'b0;
   endtask : xfer
endmodule : rsp_host_model

// ==== test_radio_spi_slave_port.sv ====
// Purpose: self-checking bench for the radio serial slave port
// Assumes: host model on the pins, crystal ticks every 4 mclk
// Notes:   register side is a small behavioural map in the bench
module test_radio_spi_slave_port;
   timeunit 1ns;
   timeprecision 1ps;
   logic       mclk = 1'b0, rst = 1'b1, flt = 1'b0, xt_run = 1'b0, xtal_tick = 1'b0;
   logic       ss_n, sck, mosi_d, mosi_en, mosi_o, mosi_oe, miso_o, miso_oe;
   logic       spi_3pin, irq_on_mosi, irq_pol_high, irq_open_drain, irq_o, irq_oe;
   logic       reg_wr, reg_rd, clkout_off, clkout_o, mosi_pin, miso_pin;
   logic [7:0] tx_status, rx_status, sys_status, tx_irq_en, rx_irq_en, sys_irq_en;
   logic [7:0] reg_wdata, reg_rdata;
   logic [5:0] reg_addr;
   logic [2:0] clkout_sel;
   logic [1:0] tcnt = 2'h0;
   logic [5:0] wa[$];
   logic [7:0] wd[$];
   int         n_errors = 0, cmp_count = 0, nrd = 0;
   // released pins show a pattern that changes every cycle
   assign mosi_pin = mosi_en ? mosi_d : (mosi_oe ? mosi_o : flt);
   assign miso_pin = miso_oe ? miso_o : flt;
   always #5 mclk = ~mclk;
   // register map: data valid the cycle after the read strobe
   always @(posedge mclk) begin
      flt <= ~flt;
      if (reg_rd) begin
         reg_rdata <= {2'h2, reg_addr};
         nrd <= nrd + 1;
      end
      if (reg_wr) begin
         wa.push_back(reg_addr);
         wd.push_back(reg_wdata);
      end
   end
   // crystal edge ticks, stopped during link tests
   always @(negedge mclk) begin
      tcnt <= tcnt + 2'h1;
      xtal_tick <= xt_run && tcnt == 2'h3;
   end
   rsp_port rsp_port_inst (.mclk, .rst, .ss_n, .sck, .mosi_i(mosi_pin), .mosi_o, .mosi_oe,
      .miso_o, .miso_oe, .spi_3pin, .irq_on_mosi, .irq_pol_high, .irq_open_drain,
      .tx_status, .rx_status, .sys_status, .tx_irq_en, .rx_irq_en, .sys_irq_en, .irq_o,
      .irq_oe, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .xtal_tick,
      .clkout_off, .clkout_sel, .clkout_o);
   rsp_host_model rsp_host_model_inst (.mclk, .spi_3pin, .miso_pin, .mosi_pin, .ss_n,
      .sck, .mosi_d, .mosi_en);
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("[FAIL] %0t ns: saw %h want %h", $time, seen, exp);
      end
   endtask : check
   task automatic results();
      $display("compares %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : results
   // write burst, address stepping or holding, wraps at 6 bits
   task automatic wr_burst(input logic inc, input logic [5:0] a, input int n);
      logic [7:0] rx;
      logic [5:0] ea;
      wa.delete();
      wd.delete();
      rsp_host_model_inst.sel(1'b0);
      rsp_host_model_inst.xfer({1'b1, inc, a}, 1'b1, rx);
      for (int k = 0; k < n; k++) rsp_host_model_inst.xfer(8'h5a ^ 8'(k), 1'b1, rx);
      rsp_host_model_inst.sel(1'b1);
      check(8'(wa.size()), 8'(n));
      for (int k = 0; k < n; k++) begin
         ea = a + (inc ? 6'(k) : 6'h0);
         check({2'h0, wa[k]}, {2'h0, ea});
         check(wd[k], 8'h5a ^ 8'(k));
      end
      $display("write burst done");
   endtask : wr_burst
   // read burst of three bytes with prefetch counted
   task automatic rd_burst(input logic inc, input logic [5:0] a, input logic three);
      logic [7:0] rx;
      logic [5:0] ea;
      int         n0;
      spi_3pin = three;
      n0 = nrd;
      rsp_host_model_inst.sel(1'b0);
      rsp_host_model_inst.xfer({1'b0, inc, a}, 1'b1, rx);
      for (int k = 0; k < 3; k++) begin
         rsp_host_model_inst.xfer(8'h00, 1'b0, rx);
         ea = a + (inc ? 6'(k) : 6'h0);
         check(rx, {2'h2, ea});
      end
      rsp_host_model_inst.sel(1'b1);
      check(8'(nrd - n0), 8'h04);
      spi_3pin = 1'b0;
      $display("read burst done");
   endtask : rd_burst
   // clocking with select high must not reach the registers
   task automatic t_ign();
      logic [7:0] rx;
      int         n0;
      n0 = nrd;
      wa.delete();
      rsp_host_model_inst.xfer(8'hc5, 1'b1, rx);
      rsp_host_model_inst.xfer(8'h33, 1'b1, rx);
      check(8'(wa.size() + nrd - n0), 8'h00);
      $display("select high test done");
   endtask : t_ign
   // each source alone, then all masked, over polarity and drive kind
   task automatic t_irq();
      logic act, lvl;
      tx_status = 8'h04;
      rx_status = 8'h20;
      sys_status = 8'h01;
      for (int i = 0; i < 16; i++) begin
         irq_pol_high = i[0];
         irq_open_drain = i[1];
         tx_irq_en = (i[3:2] == 2'h0) ? 8'h04 : 8'hfb;
         rx_irq_en = (i[3:2] == 2'h1) ? 8'h20 : 8'hdf;
         sys_irq_en = (i[3:2] == 2'h2) ? 8'h01 : 8'hfe;
         act = i[3:2] != 2'h3;
         lvl = i[0] ? act : ~act;
         repeat (4) @(negedge mclk);
         check({6'h0, irq_o, irq_oe}, i[1] ? {7'h0, ~lvl} : {6'h0, lvl, 1'b1});
      end
      // every source enabled but no status set: pin stays inactive
      {tx_status, rx_status, sys_status} = 24'h0;
      {tx_irq_en, rx_irq_en, sys_irq_en} = 24'hffffff;
      repeat (4) @(negedge mclk);
      check({6'h0, irq_o, irq_oe}, 8'h01);
      tx_status = 8'h04;
      irq_on_mosi = 1'b1;
      irq_pol_high = 1'b1;
      irq_open_drain = 1'b0;
      tx_irq_en = 8'h04;
      repeat (4) @(negedge mclk);
      check({5'h0, mosi_oe, mosi_o, irq_oe}, 8'h06);
      rsp_host_model_inst.sel(1'b0);
      check({7'h0, mosi_oe}, 8'h00);
      rsp_host_model_inst.sel(1'b1);
      irq_on_mosi = 1'b0;
      $display("interrupt test done");
   endtask : t_irq
   // period in mclk between two rising clock output samples
   task automatic rise_wait(output int n);
      n = 0;
      while (clkout_o !== 1'b0 && n < 600) begin
         @(negedge mclk);
         n++;
      end
      while (clkout_o !== 1'b1 && n < 600) begin
         @(negedge mclk);
         n++;
      end
   endtask : rise_wait
   // selections 0 to 5, code five runs at the slowest rate
   task automatic t_clk();
      int n;
      xt_run = 1'b1;
      for (int s = 0; s < 6; s++) begin
         @(negedge mclk);
         clkout_sel = 3'(s);
         rise_wait(n);
         rise_wait(n);
         rise_wait(n);
         check(8'(n), 8'(8 << (s > 4 ? 4 : s)));
      end
      @(negedge mclk);
      clkout_off = 1'b1;
      repeat (20) @(negedge mclk);
      n = 0;
      repeat (300) begin
         @(negedge mclk);
         if (clkout_o !== 1'b0) n++;
      end
      check(8'(n), 8'h00);
      $display("clock output test done");
   endtask : t_clk
   // main sequence; link tests run with crystal ticks stopped
   initial begin
      {spi_3pin, irq_on_mosi, irq_pol_high, irq_open_drain, clkout_off} = 5'h0;
      {tx_status, rx_status, sys_status} = 24'h0;
      {tx_irq_en, rx_irq_en, sys_irq_en} = 24'h0;
      clkout_sel = 3'h0;
      repeat (20) @(negedge mclk);
      rst = 1'b0;
      wr_burst(1'b1, 6'h3e, 3);
      wr_burst(1'b0, 6'h10, 2);
      rd_burst(1'b1, 6'h05, 1'b0);
      rd_burst(1'b0, 6'h21, 1'b1);
      t_ign();
      wr_burst(1'b1, 6'h2a, 1);
      t_irq();
      t_clk();
      results();
   end
   // hang guard, several times the expected run
   initial begin
      repeat (60000) @(posedge mclk);
      n_errors++;
      results();
   end
endmodule : test_radio_spi_slave_port
